// file: hdl/psb_config_regs.sv
// Phase shedding and current balance configuration register bank
// Function
// - Level-1 count writable when unlocked and indicator high or override set
// - Level-0, offset, frequency, balance registers writable whenever unlocked
// - Phase-count code n means n+1 phases; level-1 resets to 001
// - Level-0 phase count uses same code, resets to 000
// - Shedding phase counts apply only in auto-phase-shedding mode
// - Offset register bit 5 enables offset current, resets 0
// - Offset register bit 4 polarity: 0 sinking, 1 sourcing, resets 0
// - Offset bits 3:0 give magnitude 0 to 15 uA, reset 0000
// - Five-bit frequency code, 250 kHz plus 50 kHz per step, reset 0
// - Balance gain code k gives (k+1)/16, resets to 10000
// - Phase 2 and 3 get their own gain fields
// - Balance offset bit 4 direction: 0 positive, 1 negative, reset 0
// - Balance offset bits 3:0 give (k+1) x 15 mV/V, reset 0000
// - Phase 2 gets its own balance offset register
// - Auto mode compares load with threshold plus/minus margin hysteresis
`timescale 1ns/10ps
`include "psb_map.svh"
module psb_config_regs #(
    parameter int LOAD_W = 8
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire psb_pkg::psb_req_t req_i,
    output logic [7:0] rdata_o,
    input wire psb_pkg::psb_mode_t power_state_indicator_i,
    input wire logic [LOAD_W-1:0] load_i,
    input wire logic [LOAD_W-1:0] shed_load_threshold_i,
    input wire logic [LOAD_W-1:0] shed_threshold_margin_i,
    output logic [2:0] active_phase_code_o,
    output logic phase_count_valid_o,
    output psb_pkg::psb_iofs_t iofs_o,
    output logic [4:0] freq_code_o,
    output psb_pkg::psb_bal_t p1_bal_o,
    output psb_pkg::psb_bal_t p2_bal_o,
    output psb_pkg::psb_bal_t p3_bal_o
);
    logic [7:0] lock_reg;
    logic override;
    logic [2:0] shed_level1_phase_count;
    logic [2:0] shed_level0_phase_count;
    logic [5:0] offset_current_control;
    logic [4:0] switching_frequency_select;
    logic [4:0] phase1_balance_gain;
    logic [4:0] phase1_balance_offset;
    logic [4:0] phase2_balance_gain;
    logic [4:0] phase2_balance_offset;
    logic [4:0] phase3_balance_gain;
    logic [2:0] active_code;
    logic active_valid;
    logic above;

    // Address match helper
    function automatic logic hit(input psb_pkg::psb_req_t r, input logic [7:0] ofs);
        hit = r.wr && (r.addr == ofs);
    endfunction : hit

    // Write gating
    wire logic unlocked = (lock_reg != `PSB_LOCK_CODE);
    wire logic ind_high = (power_state_indicator_i == psb_pkg::PSB_MODE_HIGH);
    wire logic auto_mode = (power_state_indicator_i == psb_pkg::PSB_MODE_AUTO);
    wire logic wr_l1 = hit(req_i, `PSB_OFS_SHED_L1) && unlocked && (ind_high || override);
    wire logic wr_l0 = hit(req_i, `PSB_OFS_SHED_L0) && unlocked;
    wire logic wr_iofs = hit(req_i, `PSB_OFS_IOFS) && unlocked;
    wire logic wr_freq = hit(req_i, `PSB_OFS_FREQ) && unlocked;
    wire logic wr_g1 = hit(req_i, `PSB_OFS_P1_GAIN) && unlocked;
    wire logic wr_o1 = hit(req_i, `PSB_OFS_P1_OFFS) && unlocked;
    wire logic wr_g2 = hit(req_i, `PSB_OFS_P2_GAIN) && unlocked;
    wire logic wr_o2 = hit(req_i, `PSB_OFS_P2_OFFS) && unlocked;
    wire logic wr_g3 = hit(req_i, `PSB_OFS_P3_GAIN) && unlocked;
    wire logic wr_lock = hit(req_i, `PSB_OFS_LOCK);
    wire logic wr_ovr = hit(req_i, `PSB_OFS_OVERRIDE);

    // Lock and override registers, always writable
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lock_reg <= 8'h00;
            override <= 1'b0;
        end else begin
            if (wr_lock) lock_reg <= req_i.wdata;
            if (wr_ovr) override <= req_i.wdata[`PSB_OVERRIDE_BIT];
        end
    end

    // Phase-count registers
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            shed_level1_phase_count <= `PSB_RST_SHED_L1;
            shed_level0_phase_count <= `PSB_RST_SHED_L0;
        end else begin
            if (wr_l1) shed_level1_phase_count <= req_i.wdata[2:0];
            if (wr_l0) shed_level0_phase_count <= req_i.wdata[2:0];
        end
    end

    // Offset current and frequency registers
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            offset_current_control <= `PSB_RST_IOFS;
            switching_frequency_select <= `PSB_RST_FREQ;
        end else begin
            if (wr_iofs) offset_current_control <= req_i.wdata[5:0];
            if (wr_freq) switching_frequency_select <= req_i.wdata[4:0];
        end
    end

    // Per-phase balance registers
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            phase1_balance_gain <= `PSB_RST_GAIN;
            phase2_balance_gain <= `PSB_RST_GAIN;
            phase3_balance_gain <= `PSB_RST_GAIN;
            phase1_balance_offset <= `PSB_RST_OFFS;
            phase2_balance_offset <= `PSB_RST_OFFS;
        end else begin
            if (wr_g1) phase1_balance_gain <= req_i.wdata[4:0];
            if (wr_g2) phase2_balance_gain <= req_i.wdata[4:0];
            if (wr_g3) phase3_balance_gain <= req_i.wdata[4:0];
            if (wr_o1) phase1_balance_offset <= req_i.wdata[4:0];
            if (wr_o2) phase2_balance_offset <= req_i.wdata[4:0];
        end
    end

    psb_hyst_cmp #(
        .W(LOAD_W)
    ) u_cmp (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .enable_i(auto_mode),
        .load_i(load_i),
        .shed_load_threshold_i(shed_load_threshold_i),
        .shed_threshold_margin_i(shed_threshold_margin_i),
        .above_o(above)
    );

    // select level only in auto mode
    wire logic [2:0] next_active_code = above ? shed_level1_phase_count : shed_level0_phase_count;
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            active_code <= 3'h0;
            active_valid <= 1'b0;
        end else begin
            active_code <= auto_mode ? next_active_code : 3'h0;
            active_valid <= auto_mode;
        end
    end

    wire logic [7:0] next_rdata =
        (req_i.addr == `PSB_OFS_LOCK) ? lock_reg :
        (req_i.addr == `PSB_OFS_SHED_L1) ? {5'h00, shed_level1_phase_count} :
        (req_i.addr == `PSB_OFS_SHED_L0) ? {5'h00, shed_level0_phase_count} :
        (req_i.addr == `PSB_OFS_IOFS) ? {2'h0, offset_current_control} :
        (req_i.addr == `PSB_OFS_FREQ) ? {3'h0, switching_frequency_select} :
        (req_i.addr == `PSB_OFS_P1_GAIN) ? {3'h0, phase1_balance_gain} :
        (req_i.addr == `PSB_OFS_P1_OFFS) ? {3'h0, phase1_balance_offset} :
        (req_i.addr == `PSB_OFS_P2_GAIN) ? {3'h0, phase2_balance_gain} :
        (req_i.addr == `PSB_OFS_P2_OFFS) ? {3'h0, phase2_balance_offset} :
        (req_i.addr == `PSB_OFS_P3_GAIN) ? {3'h0, phase3_balance_gain} :
        (req_i.addr == `PSB_OFS_OVERRIDE) ? {5'h00, override, 2'h0} : 8'h00;

    // Registered read data
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= next_rdata;
        end
    end

    // Settings to the analog loop
    assign active_phase_code_o = active_code;
    assign phase_count_valid_o = active_valid;
    assign iofs_o = '{enable: offset_current_control[`PSB_IOFS_EN_BIT],
                      sourcing: offset_current_control[`PSB_IOFS_POL_BIT],
                      mag: offset_current_control[3:0]};
    assign freq_code_o = switching_frequency_select;
    assign p1_bal_o = '{gain: phase1_balance_gain, dir_neg: phase1_balance_offset[`PSB_DIR_BIT],
                        mag: phase1_balance_offset[3:0]};
    assign p2_bal_o = '{gain: phase2_balance_gain, dir_neg: phase2_balance_offset[`PSB_DIR_BIT],
                        mag: phase2_balance_offset[3:0]};
    // Phase 3 offset register lies outside this bank
    assign p3_bal_o = '{gain: phase3_balance_gain, dir_neg: 1'b0, mag: 4'h0};
endmodule : psb_config_regs

// file: hdl/psb_map.svh
// Register offsets, field positions, reset values and lock code of the shedding config bank
`ifndef PSB_MAP_SVH
`define PSB_MAP_SVH
`define PSB_OFS_LOCK 8'h00
`define PSB_OFS_SHED_L1 8'h0C
`define PSB_OFS_SHED_L0 8'h0D
`define PSB_OFS_IOFS 8'h0E
`define PSB_OFS_FREQ 8'h0F
`define PSB_OFS_P1_GAIN 8'h11
`define PSB_OFS_P1_OFFS 8'h12
`define PSB_OFS_P2_GAIN 8'h13
`define PSB_OFS_P2_OFFS 8'h14
`define PSB_OFS_P3_GAIN 8'h15
`define PSB_OFS_OVERRIDE 8'h2D
`define PSB_LOCK_CODE 8'hA6
`define PSB_OVERRIDE_BIT 2
`define PSB_IOFS_EN_BIT 5
`define PSB_IOFS_POL_BIT 4
`define PSB_DIR_BIT 4
`define PSB_RST_SHED_L1 3'h1
`define PSB_RST_SHED_L0 3'h0
`define PSB_RST_IOFS 6'h00
`define PSB_RST_FREQ 5'h00
`define PSB_RST_GAIN 5'h10
`define PSB_RST_OFFS 5'h00
`endif

// file: hdl/psb_pkg.sv
// Types shared by the shedding config bank
package psb_pkg;
    // Register access request
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } psb_req_t;
    // Per-phase balance settings
    typedef struct packed {
        logic [4:0] gain;
        logic dir_neg;
        logic [3:0] mag;
    } psb_bal_t;
    // Offset current settings
    typedef struct packed {
        logic enable;
        logic sourcing;
        logic [3:0] mag;
    } psb_iofs_t;
    // Operating mode from the power-state indicator
    typedef enum logic [1:0] {
        PSB_MODE_LOW = 2'b00,
        PSB_MODE_AUTO = 2'b01,
        PSB_MODE_HIGH = 2'b11
    } psb_mode_t;
endpackage : psb_pkg

// file: hdl/psb_hyst_cmp.sv
// Threshold comparator with hysteresis for one shedding level
`timescale 1ns/10ps
module psb_hyst_cmp #(
    parameter int W = 8
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic enable_i,
    input wire logic [W-1:0] load_i,
    input wire logic [W-1:0] shed_load_threshold_i,
    input wire logic [W-1:0] shed_threshold_margin_i,
    output logic above_o
);
    logic above;
    wire logic [W:0] upper = {1'b0, shed_load_threshold_i} + {1'b0, shed_threshold_margin_i};
    wire logic [W:0] lower = (shed_load_threshold_i > shed_threshold_margin_i) ?
        ({1'b0, shed_load_threshold_i} - {1'b0, shed_threshold_margin_i}) : '0;
    wire logic go_up = {1'b0, load_i} > upper;
    wire logic go_dn = {1'b0, load_i} < lower;
    // Hysteresis state, held low outside auto mode
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            above <= 1'b0;
        end else if (!enable_i) begin
            above <= 1'b0;
        end else if (go_up) begin
            above <= 1'b1;
        end else if (go_dn) begin
            above <= 1'b0;
        end
    end
    assign above_o = above;
endmodule : psb_hyst_cmp

// file: tb/psb_host_model.sv
// Host-side model driving the register request port
`timescale 1ns/10ps
module psb_host_model (
    input wire logic clk_sys_i,
    output psb_pkg::psb_req_t req_o,
    input wire logic [7:0] rdata_i
);
    initial req_o = '0;
    // Write strobe held over one sampling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req_o = '{wr: 1'b1, addr: a, wdata: d};
        @(posedge clk_sys_i) #1;
    endtask : wr
    // Read: address taken at one edge, data registered behind it
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        req_o = '{wr: 1'b0, addr: a, wdata: ~req_o.wdata};
        @(posedge clk_sys_i) #1;
        d = rdata_i;
    endtask : rd
endmodule : psb_host_model

// file: tb/psb_config_regs_checker.sv
// Port-level assertions for the shedding config bank
`timescale 1ns/10ps
`include "psb_map.svh"
module psb_config_regs_checker (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire psb_pkg::psb_req_t req_i,
    input wire logic [7:0] rdata_o,
    input wire psb_pkg::psb_mode_t power_state_indicator_i,
    input wire logic [2:0] active_phase_code_o,
    input wire logic phase_count_valid_o,
    input wire psb_pkg::psb_iofs_t iofs_o,
    input wire logic [4:0] freq_code_o,
    input wire psb_pkg::psb_bal_t p2_bal_o
);
    logic [7:0] lock_q;
    wire unlocked = lock_q != `PSB_LOCK_CODE;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    // Shadow of the lock register
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i)
            lock_q <= 8'h00;
        else if (req_i.wr && req_i.addr == `PSB_OFS_LOCK)
            lock_q <= req_i.wdata;
    end
    sequence s_wr(logic [7:0] a);
        req_i.wr && req_i.addr == a && unlocked;
    endsequence
    sequence s_auto2;
        power_state_indicator_i == psb_pkg::PSB_MODE_AUTO [*2];
    endsequence
    sequence s_man2;
        power_state_indicator_i != psb_pkg::PSB_MODE_AUTO [*2];
    endsequence
    property p_freq; s_wr(`PSB_OFS_FREQ) |=> freq_code_o == $past(req_i.wdata[4:0]); endproperty
    property p_iofs; s_wr(`PSB_OFS_IOFS) |=> iofs_o == $past(req_i.wdata[5:0]); endproperty
    property p_gain; s_wr(`PSB_OFS_P2_GAIN) |=> p2_bal_o.gain == $past(req_i.wdata[4:0]); endproperty
    property p_offs; s_wr(`PSB_OFS_P2_OFFS) |=> {p2_bal_o.dir_neg, p2_bal_o.mag} == $past(req_i.wdata[4:0]); endproperty
    property p_lock; req_i.wr && !unlocked |=> $stable(freq_code_o) && $stable(iofs_o) && $stable(p2_bal_o); endproperty
    property p_read; !req_i.wr && req_i.addr == `PSB_OFS_FREQ |=> rdata_o == {3'h0, $past(freq_code_o)}; endproperty
    property p_auto; s_auto2 |-> phase_count_valid_o; endproperty
    property p_man; s_man2 |-> !phase_count_valid_o && active_phase_code_o == 3'h0; endproperty
    a_freq: assert property (p_freq) else $error("frequency write lost");
    a_iofs: assert property (p_iofs) else $error("offset current write lost");
    a_gain: assert property (p_gain) else $error("phase 2 gain write lost");
    a_offs: assert property (p_offs) else $error("phase 2 offset write lost");
    a_lock: assert property (p_lock) else $error("write taken while locked");
    a_read: assert property (p_read) else $error("readback differs from stored");
    a_auto: assert property (p_auto) else $error("auto mode not flagged");
    a_man: assert property (p_man) else $error("phase code used outside auto");
endmodule : psb_config_regs_checker

// file: tb/psb_config_regs_bench.sv
// Self-checking bench for the shedding config bank
`timescale 1ns/10ps
`include "psb_map.svh"
module psb_config_regs_bench;
    logic clk_sys_i = 1'b0;
    logic rstn_i = 1'b0;
    psb_pkg::psb_req_t req;
    psb_pkg::psb_mode_t power_state_indicator = psb_pkg::PSB_MODE_LOW;
    logic [7:0] rdata, load = 8'h00;
    logic [2:0] code;
    logic valid;
    psb_pkg::psb_iofs_t iofs;
    logic [4:0] freq;
    psb_pkg::psb_bal_t b1, b2, b3;
    int fail_count = 0;
    int n_tests = 0;
    logic [7:0] rst_tab [10] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00, 8'h10, 8'h00, 8'h10};
    logic [7:0] wr_tab [10] = '{8'h01, 8'h07, 8'h3F, 8'h1F, 8'h00, 8'h1F, 8'h1F, 8'h1F, 8'h1F, 8'h1F};
    logic [7:0] ld_tab [3] = '{8'hC8, 8'h69, 8'h55};
    logic [7:0] cd_tab [3] = '{8'h83, 8'h83, 8'h87};
    always #2 clk_sys_i = ~clk_sys_i;
    psb_host_model host (.clk_sys_i(clk_sys_i), .req_o(req), .rdata_i(rdata));
    psb_config_regs uut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .req_i(req), .rdata_o(rdata),
        .power_state_indicator_i(power_state_indicator), .load_i(load), .shed_load_threshold_i(8'h64),
        .shed_threshold_margin_i(8'h0A), .active_phase_code_o(code), .phase_count_valid_o(valid),
        .iofs_o(iofs), .freq_code_o(freq), .p1_bal_o(b1), .p2_bal_o(b2), .p3_bal_o(b3));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        host.rd(a, v);
        chk(v, exp);
    endtask : rchk
    task automatic test_done;
        $display("Counts: %0d compares, %0d mismatches", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done
    // Watchdog on a hung sequence
    initial begin
        #20000;
        fail_count++;
        $display("ERROR %0t: watchdog expired", $time);
        test_done;
    end
    // Main sequence
    initial begin
        repeat (4) @(posedge clk_sys_i);
        #1 rstn_i = 1'b1;
        for (int i = 0; i < 10; i++) rchk(8'(8'h0C + i), rst_tab[i]);
        $display("Test reset values done");
        for (int i = 0; i < 10; i++) host.wr(8'(8'h0C + i), 8'hFF);
        for (int i = 0; i < 10; i++) rchk(8'(8'h0C + i), wr_tab[i]);
        chk({2'h0, iofs}, 8'h3F);
        chk({3'h0, b3.gain}, 8'h1F);
        chk({3'h0, b1.gain}, 8'h1F);
        chk({3'h0, b1.dir_neg, b1.mag}, 8'h1F);
        chk({3'h0, b2.dir_neg, b2.mag}, 8'h1F);
        chk({3'h0, freq}, 8'h1F);
        $display("Test unlocked writes done");
        host.wr(`PSB_OFS_OVERRIDE, 8'h04);
        host.wr(`PSB_OFS_SHED_L1, 8'h06);
        rchk(`PSB_OFS_SHED_L1, 8'h06);
        host.wr(`PSB_OFS_OVERRIDE, 8'h00);
        power_state_indicator = psb_pkg::PSB_MODE_HIGH;
        host.wr(`PSB_OFS_SHED_L1, 8'h03);
        rchk(`PSB_OFS_SHED_L1, 8'h03);
        host.wr(`PSB_OFS_LOCK, `PSB_LOCK_CODE);
        host.wr(`PSB_OFS_FREQ, 8'h05);
        host.wr(`PSB_OFS_SHED_L1, 8'h05);
        rchk(`PSB_OFS_FREQ, 8'h1F);
        rchk(`PSB_OFS_SHED_L1, 8'h03);
        host.wr(`PSB_OFS_LOCK, 8'h00);
        rchk(`PSB_OFS_LOCK, 8'h00);
        $display("Test gating and lock done");
        power_state_indicator = psb_pkg::PSB_MODE_AUTO;
        for (int i = 0; i < 3; i++) begin
            load = ld_tab[i];
            repeat (4) @(posedge clk_sys_i);
            #1 chk({valid, 4'h0, code}, cd_tab[i]);
        end
        power_state_indicator = psb_pkg::PSB_MODE_LOW;
        repeat (3) @(posedge clk_sys_i);
        #1 chk({valid, 4'h0, code}, 8'h00);
        $display("Test shedding mode done");
        test_done;
    end
endmodule : psb_config_regs_bench
bind psb_config_regs psb_config_regs_checker u_chk (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .req_i(req_i),
    .rdata_o(rdata_o), .power_state_indicator_i(power_state_indicator_i), .active_phase_code_o(active_phase_code_o),
    .phase_count_valid_o(phase_count_valid_o), .iofs_o(iofs_o), .freq_code_o(freq_code_o), .p2_bal_o(p2_bal_o));
